// *** shared/gx_map.svh ***
`ifndef GX_MAP_SVH
`define GX_MAP_SVH
// Behaviour
// - sixteen lines, two banks, serial bus control
// - per bank: direction, input, output, polarity
// - all lines inputs after reset
// - direction bit sets each line's driver
// - input and output registers, one bit per line
// - polarity bit inverts reported input value
// - every register readable over the bus
// - power-on reset: defaults, bus idle
// - reset pin acts like power-on reset
// - alert while any input differs from held value
// - two select pins give low address bits
// - address 11101 plus pins; last bit read
// - command byte persists for later reads
// - bank read clears only that bank's alert
// - outputs and foreign transfers never alert

// fixed upper five bits of the target address
`define GX_ADDR_HI 5'h1d
// register groups, command bits [2:1]
`define GX_GRP_INPUT 2'h0
`define GX_GRP_OUTPUT 2'h1
`define GX_GRP_POLARITY 2'h2
`define GX_GRP_CONFIG 2'h3
// reset values per bank
`define GX_OUT_RST 8'hff
`define GX_POL_RST 8'h00
`define GX_CFG_RST 8'hff
// bit counter figures
`define GX_BITS_PER_BYTE 4'h8
`define GX_LAST_TX_BIT 3'h7
// settling window after reset, one bit per cycle; the pin chain needs four
`define GX_SETTLE_RST 5'h1f
`endif

// *** shared/gx_pkg.sv ***
package gx_pkg;
	// serial target states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_WAIT
	} bus_state_t;
	// meaning of the byte being received
	typedef enum logic [1:0] {
		KIND_ADDR,
		KIND_CMD,
		KIND_DATA
	} byte_kind_t;
endpackage : gx_pkg

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-flop synchroniser; a change counts once stages two and three agree
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	// s1 is read only by s2
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			// per-bit chain plus agreement filter
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1_q[b] <= RST_VAL[b];
					s2_q[b] <= RST_VAL[b];
					s3_q[b] <= RST_VAL[b];
					o_level[b] <= RST_VAL[b];
				end else begin
					s1_q[b] <= i_async[b];
					s2_q[b] <= s1_q[b];
					s3_q[b] <= s2_q[b];
					if (s2_q[b] == s3_q[b]) begin
						o_level[b] <= s3_q[b];
					end
				end
			end
		end
	endgenerate
endmodule : pin_sync
`default_nettype wire

// *** logic/gpio_expander.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gx_map.svh"
// sixteen-line expander behind a serial target port
module gpio_expander (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// serial bus, open drain data
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	// address select straps
	input wire logic i_addr_sel_bit0,
	input wire logic i_addr_sel_bit1,
	// bank 0 pins
	input wire logic [7:0] i_io_bank_low_pins,
	output logic [7:0] o_io_bank_low_pins,
	output logic [7:0] o_io_bank_low_pins_oe,
	// bank 1 pins
	input wire logic [7:0] i_io_bank_high_pins,
	output logic [7:0] o_io_bank_high_pins,
	output logic [7:0] o_io_bank_high_pins_oe,
	// open-drain change alert, pin level low while enabled
	output logic o_alert_n,
	output logic o_alert_oe
);
	////////////////////////////////////////////////////////////////////////////
	// synchronisers
	////////////////////////////////////////////////////////////////////////////
	logic scl_s; // filtered clock level
	logic sda_s; // filtered data level
	logic a0_s; // address strap bit 0
	logic a1_s; // address strap bit 1
	logic [15:0] pins_s; // synchronised port levels

	// bus lines idle high, so reset them high to avoid a false start
	pin_sync #(.W(4), .RST_VAL(4'hf)) u_bus_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_addr_sel_bit1, i_addr_sel_bit0, i_sda, i_scl}),
		.o_level({a1_s, a0_s, sda_s, scl_s})
	);

	pin_sync #(.W(16), .RST_VAL(16'h0000)) u_pin_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_io_bank_high_pins, i_io_bank_low_pins}),
		.o_level(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// state
	////////////////////////////////////////////////////////////////////////////
	gx_pkg::bus_state_t state_q; // serial target state
	gx_pkg::byte_kind_t kind_q; // what the received byte means
	logic scl_prev_q; // for edge detection
	logic sda_prev_q;
	logic [3:0] bit_cnt_q; // bits seen in current byte
	logic [7:0] shift_q; // rx and tx shifter
	logic is_read_q; // direction of current transfer
	logic mack_q; // controller acknowledged last byte
	logic [2:0] ptr_q; // command register
	logic [15:0] out_q; // output levels, both banks
	logic [15:0] pol_q; // polarity invert, both banks
	logic [15:0] cfg_q; // 1 = input
	logic [15:0] snap_q; // held raw input values
	logic [4:0] init_q; // settling window after reset, bit 0 loads snap
	logic sda_oe_q; // drive data low
	logic alert_q; // alert enable

	////////////////////////////////////////////////////////////////////////////
	// decoding
	////////////////////////////////////////////////////////////////////////////
	wire scl_rise = scl_s & ~scl_prev_q;
	wire scl_fall = ~scl_s & scl_prev_q;
	// data moving while clock high marks start or stop
	wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	wire [6:0] my_addr = {`GX_ADDR_HI, a1_s, a0_s};
	wire addr_hit = (shift_q[7:1] == my_addr);
	wire byte_done = (bit_cnt_q == `GX_BITS_PER_BYTE);
	wire [1:0] grp = ptr_q[2:1];
	wire bank = ptr_q[0];
	wire [3:0] lane = {bank, 3'h0};
	// reported input is pin level xor polarity
	wire [15:0] in_view = pins_s ^ pol_q;
	wire [7:0] rd_byte = (grp == `GX_GRP_INPUT) ? in_view[lane +: 8] :
		(grp == `GX_GRP_OUTPUT) ? out_q[lane +: 8] :
		(grp == `GX_GRP_POLARITY) ? pol_q[lane +: 8] : cfg_q[lane +: 8];
	wire rd_input = (grp == `GX_GRP_INPUT);
	// alert per bank, masked by direction so outputs never count
	wire [15:0] diff = (pins_s ^ snap_q) & cfg_q;
	wire alert_any = (|diff[7:0]) | (|diff[15:8]);
	// a read of an input bank loads a byte and re-captures that bank only
	wire load_tx = (state_q == gx_pkg::ST_ACK && scl_fall && is_read_q) ||
		(state_q == gx_pkg::ST_MACK && scl_fall && mack_q);
	wire snap_load = load_tx && rd_input;

	////////////////////////////////////////////////////////////////////////////
	// serial target state machine
	////////////////////////////////////////////////////////////////////////////
	// start and stop override every state; reset returns to idle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= gx_pkg::ST_IDLE;
			kind_q <= gx_pkg::KIND_ADDR;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			is_read_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			if (start_cond) begin
				// also serves repeated start
				state_q <= gx_pkg::ST_RX;
				kind_q <= gx_pkg::KIND_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_cond) begin
				state_q <= gx_pkg::ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
					gx_pkg::ST_RX: begin
						// sample on rise, judge byte at the following fall
						if (scl_rise && !byte_done) begin
							shift_q <= {shift_q[6:0], sda_s};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end else if (scl_fall && byte_done) begin
							if (kind_q != gx_pkg::KIND_ADDR || addr_hit) begin
								state_q <= gx_pkg::ST_ACK;
								sda_oe_q <= 1'b1;
							end else begin
								// not ours: stay off the bus until next start
								state_q <= gx_pkg::ST_WAIT;
							end
							if (kind_q == gx_pkg::KIND_ADDR) begin
								is_read_q <= shift_q[0];
							end
						end
					end
					gx_pkg::ST_ACK: begin
						// release after the acknowledge clock
						if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							if (is_read_q) begin
								shift_q <= rd_byte;
								sda_oe_q <= ~rd_byte[7];
								state_q <= gx_pkg::ST_TX;
							end else begin
								sda_oe_q <= 1'b0;
								state_q <= gx_pkg::ST_RX;
								kind_q <= (kind_q == gx_pkg::KIND_ADDR) ?
									gx_pkg::KIND_CMD : gx_pkg::KIND_DATA;
							end
						end
					end
					gx_pkg::ST_TX: begin
						// shift out on each fall, msb first
						if (scl_fall) begin
							if (bit_cnt_q[2:0] == `GX_LAST_TX_BIT) begin
								sda_oe_q <= 1'b0;
								state_q <= gx_pkg::ST_MACK;
							end else begin
								sda_oe_q <= ~shift_q[6];
								shift_q <= {shift_q[6:0], 1'b0};
								bit_cnt_q <= bit_cnt_q + 4'h1;
							end
						end
					end
					gx_pkg::ST_MACK: begin
						// low data means the controller wants more
						if (scl_rise) begin
							mack_q <= ~sda_s;
						end else if (scl_fall) begin
							bit_cnt_q <= 4'h0;
							if (mack_q) begin
								shift_q <= rd_byte;
								sda_oe_q <= ~rd_byte[7];
								state_q <= gx_pkg::ST_TX;
							end else begin
								state_q <= gx_pkg::ST_WAIT;
							end
						end
					end
					gx_pkg::ST_WAIT: begin
						sda_oe_q <= 1'b0;
					end
					default: begin
						// idle and anything unexpected
						sda_oe_q <= 1'b0;
						state_q <= gx_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command register and pair pointer
	////////////////////////////////////////////////////////////////////////////
	wire rx_commit = (state_q == gx_pkg::ST_RX) && scl_fall && byte_done &&
		!start_cond && !stop_cond;
	wire cmd_wr = rx_commit && (kind_q == gx_pkg::KIND_CMD);
	wire data_wr = rx_commit && (kind_q == gx_pkg::KIND_DATA);

	// pointer toggles within its pair after each data byte
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_q <= 3'h0;
		end else if (cmd_wr) begin
			ptr_q <= shift_q[2:0];
		end else if (data_wr || load_tx) begin
			ptr_q <= {ptr_q[2:1], ~ptr_q[0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file
	////////////////////////////////////////////////////////////////////////////
	// writes to the input group are ignored, it is read only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_q <= {`GX_OUT_RST, `GX_OUT_RST};
			pol_q <= {`GX_POL_RST, `GX_POL_RST};
			cfg_q <= {`GX_CFG_RST, `GX_CFG_RST};
		end else if (data_wr) begin
			case (grp)
				`GX_GRP_OUTPUT: out_q[lane +: 8] <= shift_q;
				`GX_GRP_POLARITY: pol_q[lane +: 8] <= shift_q;
				`GX_GRP_CONFIG: cfg_q[lane +: 8] <= shift_q;
				default: begin
					// input group: nothing to store
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input hold register and alert
	////////////////////////////////////////////////////////////////////////////
	// snap follows the pins until the synchroniser has settled;
	// loading earlier would hold reset zeros and a high pin would alert falsely
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			init_q <= `GX_SETTLE_RST;
			snap_q <= 16'h0000;
		end else begin
			init_q <= {1'b0, init_q[4:1]};
			if (init_q[0]) begin
				snap_q <= pins_s;
			end else if (snap_load) begin
				snap_q[lane +: 8] <= pins_s[lane +: 8];
			end
		end
	end

	// registered alert; a change after a bank read raises it again
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_any && !init_q[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins
	////////////////////////////////////////////////////////////////////////////
	// open-drain lines only ever pull low
	assign o_sda = 1'b0;
	assign o_sda_oe = sda_oe_q;
	assign o_alert_n = 1'b0;
	assign o_alert_oe = alert_q;
	// per-line driver follows the direction bit
	assign o_io_bank_low_pins = out_q[7:0];
	assign o_io_bank_high_pins = out_q[15:8];
	assign o_io_bank_low_pins_oe = ~cfg_q[7:0];
	assign o_io_bank_high_pins_oe = ~cfg_q[15:8];
endmodule : gpio_expander
`default_nettype wire

// *** verification/gpio_expander_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the expander's pins only
module gpio_expander_checker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic [7:0] i_io_bank_low_pins,
	input wire logic [7:0] o_io_bank_low_pins,
	input wire logic [7:0] o_io_bank_low_pins_oe,
	input wire logic [7:0] i_io_bank_high_pins,
	input wire logic [7:0] o_io_bank_high_pins,
	input wire logic [7:0] o_io_bank_high_pins_oe,
	input wire logic o_alert_n,
	input wire logic o_alert_oe
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////
	// levels of lines set as inputs, plus the direction bits
	wire logic [15:0] oe = {o_io_bank_high_pins_oe, o_io_bank_low_pins_oe};
	wire logic [15:0] in_lv = {i_io_bank_high_pins, i_io_bank_low_pins} & ~oe;
	logic [31:0] seen_q;
	logic [3:0] quiet_q;
	// cycles since an input line or a direction last moved; saturates
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_q <= '0;
			quiet_q <= '0;
		end else begin
			seen_q <= {in_lv, oe};
			quiet_q <= ({in_lv, oe} != seen_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
		end
	end
	////////////////////////////////////////////////////////////////
	a_reset_defaults: assert property (
		$rose(i_rst_n) |-> !o_sda_oe && !o_alert_oe && oe == 16'h0000
		&& {o_io_bank_high_pins, o_io_bank_low_pins} == 16'hffff)
		else $error("outputs not at defaults after reset");
	a_open_drain: assert property (o_sda == 1'b0 && o_alert_n == 1'b0)
		else $error("open-drain value not low");
	a_sda_turn: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("data driver moved while clock high");
	a_sda_steady: assert property (i_scl [*6] |-> $stable(o_sda_oe))
		else $error("data driver moved in clock high phase");
	a_dir_update: assert property ($changed(oe) |-> !i_scl)
		else $error("direction moved while clock high");
	a_out_update: assert property (
		$changed({o_io_bank_high_pins, o_io_bank_low_pins}) |-> $past(i_scl, 2) == 1'b0)
		else $error("output levels moved outside clock low");
	a_alert_raise: assert property (
		($changed(in_lv) && !o_alert_oe && $stable(oe)) ##1
		(i_scl && $stable(in_lv)) [*7] |-> ##[0:2] o_alert_oe)
		else $error("alert missing after input change");
	a_alert_quiet: assert property (quiet_q >= 4'ha && !o_alert_oe |=> !o_alert_oe)
		else $error("alert without input change");
	// main scenarios
	c_alert_up: cover property ($rose(o_alert_oe));
	c_alert_down: cover property ($fell(o_alert_oe));
	c_ack: cover property ($rose(o_sda_oe));
endmodule : gpio_expander_checker
bind gpio_expander gpio_expander_checker chk_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_scl(i_scl), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_alert_n(o_alert_n),
	.i_io_bank_low_pins(i_io_bank_low_pins), .o_io_bank_low_pins(o_io_bank_low_pins),
	.o_io_bank_low_pins_oe(o_io_bank_low_pins_oe), .i_io_bank_high_pins(i_io_bank_high_pins),
	.o_io_bank_high_pins(o_io_bank_high_pins), .o_alert_oe(o_alert_oe),
	.o_io_bank_high_pins_oe(o_io_bank_high_pins_oe));
`default_nettype wire

// *** verification/i2c_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus controller; 800 ns bit: six clocks low, two high; clock stands high when idle
module i2c_ctl (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// data moves three clocks into the low phase; the long low phase leaves room
	// for the target's answer, which lands five clocks after the clock falls
	task automatic bitx(input logic v, output logic r);
		repeat (3) @(posedge i_clk);
		o_sda <= v;
		repeat (3) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (2) @(posedge i_clk);
		r = i_sda;
		o_scl <= 1'b0;
	endtask : bitx
	// start or repeated start: data up while clock low, then falls under a high clock
	task automatic start();
		repeat (3) @(posedge i_clk);
		o_sda <= 1'b1;
		repeat (7) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (10) @(posedge i_clk);
		o_sda <= 1'b0;
		repeat (10) @(posedge i_clk);
		o_scl <= 1'b0;
	endtask : start
	// data low while clock low, then rises under a high clock
	task automatic stop();
		repeat (3) @(posedge i_clk);
		o_sda <= 1'b0;
		repeat (7) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (10) @(posedge i_clk);
		o_sda <= 1'b1;
		repeat (10) @(posedge i_clk);
	endtask : stop
	// address with direction bit, command or data byte, msb first
	task automatic wr(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask : wr
	// last byte answered with a nack
	task automatic rd(output logic [7:0] v, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
		bitx(last, r);
	endtask : rd
endmodule : i2c_ctl
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [7:0] ext [2];
	logic [7:0] m [4][2];
	logic [7:0] b;
	logic a;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	wire logic scl, csda, sda_oe, sda, alert;
	wire logic [7:0] o0, o1, e0, e1, p0, p1;
	// pulled-up data line; driven pins follow the outputs
	assign sda = csda & ~sda_oe;
	assign p0 = (e0 & o0) | (~e0 & ext[0]);
	assign p1 = (e1 & o1) | (~e1 & ext[1]);
	always #50 i_clk = ~i_clk;
	gpio_expander gpio_expander_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl),
		.i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .i_addr_sel_bit0(sel[0]),
		.i_addr_sel_bit1(sel[1]), .i_io_bank_low_pins(p0), .o_io_bank_low_pins(o0),
		.o_io_bank_low_pins_oe(e0), .i_io_bank_high_pins(p1), .o_io_bank_high_pins(o1),
		.o_io_bank_high_pins_oe(e1), .o_alert_n(), .o_alert_oe(alert));
	i2c_ctl i2c_ctl_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(csda));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	// model: group 0 reads live pins through the inversion mask
	function automatic logic [7:0] ev(input logic [1:0] g, input logic k);
		return (g == 2'h0) ? ((k ? p1 : p0) ^ m[2][k]) : m[g][k];
	endfunction : ev
	task automatic wreg(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1);
		i2c_ctl_inst.start();
		i2c_ctl_inst.wr({5'h1d, sel, 1'b0}, a);
		chk({15'h0, a}, 16'h0001);
		i2c_ctl_inst.wr(c, a);
		i2c_ctl_inst.wr(d0, a);
		i2c_ctl_inst.wr(d1, a);
		i2c_ctl_inst.stop();
		// writes to the input group are dropped
		if (c[2:1] != 2'h0) begin
			m[c[2:1]][c[0]] = d0;
			m[c[2:1]][!c[0]] = d1;
		end
		chk({e1, e0}, ~{m[3][1], m[3][0]});
		chk({o1, o0}, {m[1][1], m[1][0]});
	endtask : wreg
	// n bytes from pair c; nc reuses the last command
	task automatic rreg(input logic [7:0] c, input int n, input logic nc);
		if (!nc) begin
			i2c_ctl_inst.start();
			i2c_ctl_inst.wr({5'h1d, sel, 1'b0}, a);
			i2c_ctl_inst.wr(c, a);
		end
		i2c_ctl_inst.start();
		i2c_ctl_inst.wr({5'h1d, sel, 1'b1}, a);
		chk({15'h0, a}, 16'h0001);
		for (int i = 0; i < n; i++) begin
			i2c_ctl_inst.rd(b, i == n - 1);
			chk({8'h0, b}, {8'h0, ev(c[2:1], c[0] ^ i[0])});
		end
		i2c_ctl_inst.stop();
	endtask : rreg
	task automatic wait_chk_alert(input logic v);
		repeat (12) @(posedge i_clk);
		chk({15'h0, alert}, {15'h0, v});
	endtask : wait_chk_alert
	////////////////////////////////////////////////////////////////
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		m = '{'{8'h00, 8'h00}, '{8'hff, 8'hff}, '{8'h00, 8'h00}, '{8'hff, 8'hff}};
		void'($urandom(89));
		sel = 2'($urandom);
		ext[0] = 8'h00;
		ext[1] = 8'($urandom);
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (8) @(posedge i_clk);
		chk({e1, e0}, 16'h0000);
		chk({o1, o0}, 16'hffff);
		chk({15'h0, alert}, 16'h0000);
		for (int g = 0; g < 4; g++) rreg({5'h0, g[1:0], 1'b0}, 2, 1'b0);
		$display("test reset done");
		wreg(8'h06, 8'h0f & 8'($urandom), 8'hff);
		wreg(8'h02, 8'($urandom), 8'($urandom));
		wreg(8'h05, 8'($urandom), 8'($urandom));
		wreg(8'h00, 8'h55, 8'haa);
		for (int g = 0; g < 4; g++) rreg({5'h0, g[1:0], 1'b1}, 2, 1'b0);
		rreg(8'h07, 1, 1'b1);
		$display("test access done");
		ext[1] <= ext[1] ^ 8'h80;
		wait_chk_alert(1'b1);
		// foreign address: refused, alert untouched
		i2c_ctl_inst.start();
		i2c_ctl_inst.wr({5'h1d, ~sel, 1'b0}, a);
		chk({15'h0, a}, 16'h0000);
		i2c_ctl_inst.stop();
		chk({15'h0, alert}, 16'h0001);
		rreg(8'h00, 1, 1'b0);
		chk({15'h0, alert}, 16'h0001);
		rreg(8'h01, 1, 1'b0);
		chk({15'h0, alert}, 16'h0000);
		ext[1] <= ext[1] ^ 8'h01;
		wait_chk_alert(1'b1);
		ext[1] <= ext[1] ^ 8'h01;
		wait_chk_alert(1'b0);
		$display("test alert done");
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		m = '{'{8'h00, 8'h00}, '{8'hff, 8'hff}, '{8'h00, 8'h00}, '{8'hff, 8'hff}};
		repeat (8) @(posedge i_clk);
		chk({e1, e0}, 16'h0000);
		chk({o1, o0}, 16'hffff);
		chk({15'h0, alert}, 16'h0000);
		rreg(8'h04, 2, 1'b0);
		$display("test reset pin done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
